/* pkg/memory_write_cycle_protect_defines.svh */
// Purpose: offsets, field positions, reset values and timing for the write-cycle front end
// Assumes: 50 MHz clock, Wishbone register bus with 32-bit data
// Notes: byte addresses of one aligned word per register
`ifndef MEMORY_WRITE_CYCLE_PROTECT_DEFINES_SVH
`define MEMORY_WRITE_CYCLE_PROTECT_DEFINES_SVH

// ==========================================================================
// register map
`define REG_STATUS_ADDR 8'h00
`define REG_CLEAR_ADDR 8'h04
`define REG_ENABLE_ADDR 8'h08
`define REG_CONTROL_ADDR 8'h0C
`define REG_STATE_ADDR 8'h10

// ==========================================================================
// event bits of status, clear and enable
`define EVENT_COUNT 4
`define EV_PROTECT_ERROR 0
`define EV_WRITE_DONE 1
`define EV_READ_DONE 2
`define EV_TRANSFER_DONE 3
`define EVENT_RESET 4'h0

// control register fields
`define CTRL_CYCLE_ENABLE 0
`define CTRL_CLEAR_PROTECT 1
`define CTRL_RESET 2'h1

// state register fields
`define STATE_PROTECT_LATCH 0
`define STATE_WRITE_ENABLE 1
`define STATE_TRANSFER 2
`define STATE_BUSY 3

// ==========================================================================
// address and data layout
`define ADDR_WIDTH 11
`define ADDR_REGION_MSB 10
`define ADDR_REGION_LSB 7
`define ADDR_REGION_LOW 4'h0
`define DATA_WIDTH 64
`define OUTER_HALF_MASK 64'hFFFF_FF00_0000_00FF

// data select codes, 1 meaning the line is low
`define DSEL_CU 2'b00
`define DSEL_BUFFER 2'b01
`define DSEL_IO 2'b10
`define DSEL_PE 2'b11

// ==========================================================================
// timing
`define CLOCK_PERIOD_NS 20
`define WRITE_DELAY_NS 75
`define WRITE_PULSE_NS 50
`define WRITE_DELAY_CYCLES ((`WRITE_DELAY_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define WRITE_PULSE_CYCLES (`WRITE_PULSE_NS / `CLOCK_PERIOD_NS)
`define READ_PULSE_CYCLES 1

`endif

/* pkg/memory_write_cycle_protect_pkg.sv */
// Purpose: types shared by the write-cycle front end
// Assumes: nothing beyond the defines header
// Notes: one-hot state codes written out
package memory_write_cycle_protect_pkg;

  // ========================================================================
  // cycle sequencer
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_INIT = 4'b0100,
    ST_XFER = 4'b1000
  } cycle_state_t;

endpackage

/* src/pin_synchronizer.sv */
// Purpose: two flip-flop synchroniser for a bus of pin inputs
// Assumes: inputs come from outside the clock domain
// Notes: the first stage is read only by the second
`timescale 1ns/100ps

module pin_synchronizer
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // ========================================================================
  // per-bit stages
  genvar bit_index;
  generate
    for (bit_index = 0; bit_index < WIDTH; bit_index = bit_index + 1)
    begin : g_bit
      always_ff @(posedge i_clock or negedge i_reset_n)
      begin
        if (!i_reset_n)
        begin
          stage1_reg[bit_index] <= RESET_VALUE[bit_index];
          stage2_reg[bit_index] <= RESET_VALUE[bit_index];
        end
        else
        begin
          stage1_reg[bit_index] <= i_async[bit_index];
          stage2_reg[bit_index] <= stage1_reg[bit_index];
        end
      end
    end
  endgenerate

  assign o_sync = stage2_reg;

endmodule // pin_synchronizer

/* src/memory_write_cycle_protect.sv */
// Purpose: write-cycle front end between processing element and element memory
// Assumes: pins synchronised here; Wishbone classic slave for status and control
// Notes: low-region protect error blocks the write and sets the latch; the pulse is held back until
//   the protect check has had its time
//
// Added by the designer: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "memory_write_cycle_protect_defines.svh"

module memory_write_cycle_protect
#(
  parameter int DELAY_CYCLES = `WRITE_DELAY_CYCLES,
  parameter int PULSE_CYCLES = `WRITE_PULSE_CYCLES
)
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_memory_select_n,
  input wire logic i_initiate_cycle_request_n,
  input wire logic i_read_not_write_n,
  input wire logic i_protect_low_region_request_n,
  input wire logic i_protect_error_clear,
  input wire logic i_transfer_request_n,
  input wire logic [1:0] i_data_select_n,
  input wire logic [1:0] i_half_select_n,
  input wire logic [10:0] i_word_address_n,
  input wire logic [63:0] i_pe_write_data_n,
  input wire logic [63:0] i_io_write_data_n,
  input wire logic [63:0] i_element_read_data_n,
  output logic [10:0] o_element_address,
  output logic [63:0] o_element_write_data,
  output logic o_memory_initiate_pulse,
  output logic o_write_enable_outer,
  output logic o_write_enable_inner,
  output logic [63:0] o_outbound_data,
  output logic o_outbound_to_buffer,
  output logic o_outbound_valid,
  output logic o_protect_error,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output logic o_interrupt
);
  import memory_write_cycle_protect_pkg::*;

  localparam int SYNC_WIDTH = 10 + `ADDR_WIDTH + 3 * `DATA_WIDTH;
  localparam int COUNT_WIDTH = 4;

  // ========================================================================
  // pin synchronisers; low-true lines idle high
  logic [SYNC_WIDTH-1:0] sync_in;
  logic [SYNC_WIDTH-1:0] sync_out;
  logic s_select_n;
  logic s_initiate_n;
  logic s_read_n;
  logic s_protect_n;
  logic s_clear;
  logic s_transfer_n;
  logic [1:0] s_dsel_n;
  logic [1:0] s_half_n;
  logic [10:0] s_addr_n;
  logic [63:0] s_pe_n;
  logic [63:0] s_io_n;
  logic [63:0] s_rd_n;

  assign sync_in = {i_memory_select_n, i_initiate_cycle_request_n, i_read_not_write_n,
                    i_protect_low_region_request_n, i_protect_error_clear,
                    i_transfer_request_n, i_data_select_n, i_half_select_n,
                    i_word_address_n, i_pe_write_data_n, i_io_write_data_n,
                    i_element_read_data_n};
  assign {s_select_n, s_initiate_n, s_read_n, s_protect_n, s_clear, s_transfer_n,
          s_dsel_n, s_half_n, s_addr_n, s_pe_n, s_io_n, s_rd_n} = sync_out;

  pin_synchronizer #(
    .WIDTH(SYNC_WIDTH),
    .RESET_VALUE({{6{1'b1}}, 4'hF, {(`ADDR_WIDTH + 3 * `DATA_WIDTH){1'b1}}} & ~
                 {4'h0, 1'b1, 1'b0, 4'h0, {(`ADDR_WIDTH + 3 * `DATA_WIDTH){1'b0}}})
  ) u_sync (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_async(sync_in),
    .o_sync(sync_out)
  );

  // ========================================================================
  // decoding of the negative-logic controls
  logic select_active;
  logic initiate_active;
  logic is_read;
  logic protect_active;
  logic transfer_active;
  logic [1:0] dsel;
  logic [1:0] half;
  logic [10:0] address;
  logic [63:0] pe_data;
  logic [63:0] io_data;
  logic [63:0] read_data;
  logic full_word_source;
  logic low_region;

  assign select_active = ~s_select_n;
  assign initiate_active = ~s_initiate_n;
  assign is_read = ~s_read_n;
  assign protect_active = ~s_protect_n;
  assign transfer_active = ~s_transfer_n;
  assign dsel = ~s_dsel_n;
  assign half = ~s_half_n;
  assign address = ~s_addr_n;
  assign pe_data = ~s_pe_n;
  assign io_data = ~s_io_n;
  assign read_data = ~s_rd_n;
  assign full_word_source = (dsel == `DSEL_CU) || (dsel == `DSEL_IO);
  assign low_region = address[`ADDR_REGION_MSB:`ADDR_REGION_LSB] == `ADDR_REGION_LOW;

  // ========================================================================
  // registers
  cycle_state_t state_reg;
  cycle_state_t state_next;
  logic [COUNT_WIDTH-1:0] count_reg;
  logic [COUNT_WIDTH-1:0] count_next;
  logic request_prev_reg;
  logic transfer_prev_reg;
  logic read_cycle_reg;
  logic write_enable_reg;
  logic protect_latch_reg;
  logic transfer_reg;
  logic en_outer_reg;
  logic en_inner_reg;
  logic [10:0] address_reg;
  logic [63:0] write_data_reg;
  logic [63:0] outbound_reg;
  logic outbound_buffer_reg;
  logic outbound_valid_reg;
  logic [1:0] read_wait_reg;
  logic [`EVENT_COUNT-1:0] status_reg;
  logic [`EVENT_COUNT-1:0] enable_reg;
  logic [1:0] control_reg;
  logic ack_reg;

  // ========================================================================
  // cycle start and protect check
  logic request;
  logic start;
  logic transfer_start;
  logic protect_hit;
  logic write_start;
  logic read_start;
  logic [63:0] half_mask;
  logic [63:0] write_word;
  logic wait_done;
  logic init_done;
  logic sw_clear_protect;
  logic wb_write;

  assign request = select_active & initiate_active;
  assign start = request & ~request_prev_reg & (state_reg == ST_IDLE)
                 & control_reg[`CTRL_CYCLE_ENABLE];
  assign transfer_start = transfer_active & ~transfer_prev_reg & ~start
                          & (state_reg == ST_IDLE);
  // a write overlapping a transfer is dropped, never half done
  assign write_start = start & ~is_read & ~transfer_reg;
  assign read_start = start & is_read;
  assign protect_hit = write_start & protect_active & low_region;
  // processing element data is gated by the half bits; control unit and io data go whole
  assign half_mask = ({64{half[0]}} & `OUTER_HALF_MASK)
                     | ({64{half[1]}} & ~`OUTER_HALF_MASK);
  assign write_word = (dsel == `DSEL_IO) ? io_data
                      : (full_word_source ? pe_data : (pe_data & half_mask));
  assign wait_done = (state_reg == ST_WAIT) && (count_reg == '0);
  assign init_done = (state_reg == ST_INIT) && (count_reg == '0);

  // ========================================================================
  // sequencer
  always_comb
  begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (write_start)
        begin
          state_next = ST_WAIT;
          count_next = COUNT_WIDTH'(DELAY_CYCLES - 1);
        end
        else if (read_start)
        begin
          state_next = ST_INIT; // read skips the protect delay
          count_next = COUNT_WIDTH'(`READ_PULSE_CYCLES - 1);
        end
        else if (transfer_start)
        begin
          state_next = ST_XFER;
        end
      end
      ST_WAIT:
      begin
        if (count_reg != '0)
        begin
          count_next = count_reg - 1'b1;
        end
        else if (write_enable_reg && !transfer_reg)
        begin
          state_next = ST_INIT;
          count_next = COUNT_WIDTH'(PULSE_CYCLES - 1);
        end
        else
        begin
          state_next = ST_IDLE; // protect error: no pulse
        end
      end
      ST_INIT:
      begin
        if (count_reg != '0)
        begin
          count_next = count_reg - 1'b1;
        end
        else
        begin
          state_next = ST_IDLE;
        end
      end
      ST_XFER:
      begin
        state_next = ST_IDLE;
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_reg <= ST_IDLE;
      count_reg <= '0;
      request_prev_reg <= 1'b0;
      transfer_prev_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
      request_prev_reg <= request;
      transfer_prev_reg <= transfer_active;
    end
  end

  // ========================================================================
  // write enable flop, protect latch and transfer flop
  assign sw_clear_protect = wb_write && (i_wb_adr == `REG_CONTROL_ADDR) && i_wb_sel[0]
                            && i_wb_dat[`CTRL_CLEAR_PROTECT];

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      write_enable_reg <= 1'b1;
      protect_latch_reg <= 1'b0;
      transfer_reg <= 1'b0;
    end
    else
    begin
      // the enable is re-armed once the cycle ends; the latch plays no part
      if (protect_hit)
        write_enable_reg <= 1'b0;
      else if (state_reg == ST_IDLE)
        write_enable_reg <= 1'b1;
      // a new error wins over a clear in the same cycle
      if (protect_hit)
        protect_latch_reg <= 1'b1;
      else if (s_clear || sw_clear_protect)
        protect_latch_reg <= 1'b0;
      transfer_reg <= (state_next == ST_XFER);
    end
  end

  // ========================================================================
  // address, write data and outbound data stores
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      address_reg <= '0;
      write_data_reg <= '0;
      en_outer_reg <= 1'b0;
      en_inner_reg <= 1'b0;
      read_cycle_reg <= 1'b0;
      outbound_reg <= '0;
      outbound_buffer_reg <= 1'b0;
      outbound_valid_reg <= 1'b0;
      read_wait_reg <= 2'h0;
    end
    else
    begin
      if (start)
      begin
        address_reg <= address;
        read_cycle_reg <= is_read;
      end
      if (write_start)
      begin
        write_data_reg <= write_word;
        en_outer_reg <= ~protect_hit & (full_word_source | half[0]);
        en_inner_reg <= ~protect_hit & (full_word_source | half[1]);
      end
      // read lines come through the synchroniser: wait out both stages
      read_wait_reg <= {read_wait_reg[0], init_done & read_cycle_reg};
      outbound_valid_reg <= 1'b0;
      if (read_wait_reg[1])
      begin
        // one output path serves io and buffer alike
        outbound_reg <= read_data;
        outbound_buffer_reg <= (dsel == `DSEL_BUFFER);
        outbound_valid_reg <= 1'b1;
      end
      else if (transfer_start)
      begin
        outbound_reg <= pe_data & half_mask;
        outbound_buffer_reg <= 1'b1;
        outbound_valid_reg <= 1'b1;
      end
    end
  end

  assign o_element_address = address_reg;
  assign o_element_write_data = write_data_reg;
  assign o_memory_initiate_pulse = (state_reg == ST_INIT);
  assign o_write_enable_outer = (state_reg == ST_INIT) & ~read_cycle_reg & en_outer_reg;
  assign o_write_enable_inner = (state_reg == ST_INIT) & ~read_cycle_reg & en_inner_reg;
  assign o_outbound_data = outbound_reg;
  assign o_outbound_to_buffer = outbound_buffer_reg;
  assign o_outbound_valid = outbound_valid_reg;
  assign o_protect_error = protect_latch_reg;

  // ========================================================================
  // register bus and interrupt
  logic wb_access;
  logic [`EVENT_COUNT-1:0] events;
  logic [`EVENT_COUNT-1:0] clear_bits;
  logic [31:0] read_word;

  assign wb_access = i_wb_cyc & i_wb_stb & ~ack_reg;
  assign wb_write = wb_access & i_wb_we;
  assign events[`EV_PROTECT_ERROR] = protect_hit;
  assign events[`EV_WRITE_DONE] = init_done & ~read_cycle_reg;
  assign events[`EV_READ_DONE] = init_done & read_cycle_reg;
  assign events[`EV_TRANSFER_DONE] = (state_reg == ST_XFER);
  assign clear_bits = (wb_write && (i_wb_adr == `REG_CLEAR_ADDR) && i_wb_sel[0])
                      ? i_wb_dat[`EVENT_COUNT-1:0] : '0;
  assign read_word = (i_wb_adr == `REG_STATUS_ADDR) ? {28'h000_0000, status_reg}
                   : (i_wb_adr == `REG_ENABLE_ADDR) ? {28'h000_0000, enable_reg}
                   : (i_wb_adr == `REG_CONTROL_ADDR) ? {30'h0000_0000, control_reg}
                   : (i_wb_adr == `REG_STATE_ADDR) ? {28'h000_0000, state_reg != ST_IDLE,
                      transfer_reg, write_enable_reg, protect_latch_reg}
                   : 32'h0000_0000;

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      status_reg <= `EVENT_RESET;
      enable_reg <= `EVENT_RESET;
      control_reg <= `CTRL_RESET;
      ack_reg <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= wb_access;
      if (wb_access && !i_wb_we)
        o_wb_dat <= read_word;
      // new events win over a clear in the same cycle
      status_reg <= (status_reg & ~clear_bits) | events;
      if (wb_write && (i_wb_adr == `REG_ENABLE_ADDR) && i_wb_sel[0])
        enable_reg <= i_wb_dat[`EVENT_COUNT-1:0];
      if (wb_write && (i_wb_adr == `REG_CONTROL_ADDR) && i_wb_sel[0])
        control_reg <= {1'b0, i_wb_dat[`CTRL_CYCLE_ENABLE]};
    end
  end

  assign o_wb_ack = ack_reg;
  assign o_interrupt = |(status_reg & enable_reg);

endmodule // memory_write_cycle_protect

/* sim/memory_write_cycle_protect_properties.sv */
// Purpose: port-level checks of the write-cycle front end
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to every instance of the top module
`timescale 1ns/100ps
`include "memory_write_cycle_protect_defines.svh"

module memory_write_cycle_protect_properties
#(
  parameter int DELAY_CYCLES = `WRITE_DELAY_CYCLES,
  parameter int PULSE_CYCLES = `WRITE_PULSE_CYCLES
)
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_initiate_cycle_request_n,
  input wire logic i_read_not_write_n,
  input wire logic i_protect_error_clear,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic [10:0] o_element_address,
  input wire logic [63:0] o_element_write_data,
  input wire logic o_memory_initiate_pulse,
  input wire logic o_write_enable_outer,
  input wire logic o_write_enable_inner,
  input wire logic o_outbound_valid,
  input wire logic o_protect_error,
  input wire logic o_wb_ack
);
  // ==========================================================================
  // common terms
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  logic wr_en;
  assign wr_en = o_write_enable_outer | o_write_enable_inner;

  // ==========================================================================
  // assertions
  a_ack_follows_req: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("ack missing one cycle after a taken request");
  a_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack stood longer than one cycle");
  a_enable_in_pulse: assert property (wr_en |-> o_memory_initiate_pulse)
    else $error("write enable outside the initiate pulse");
  a_write_pulse_width: assert property ($rose(o_memory_initiate_pulse) && wr_en |=>
    o_memory_initiate_pulse ##1 !o_memory_initiate_pulse)
    else $error("write pulse not two cycles wide");
  // the delay gives the protect check its time before anything reaches memory
  a_write_delay: assert property ($fell(i_initiate_cycle_request_n) && i_read_not_write_n
    |-> (!o_memory_initiate_pulse) [*5])
    else $error("write pulse came before the protect delay");
  a_protect_quiet: assert property ($rose(o_protect_error) |->
    (!(o_memory_initiate_pulse || wr_en)) [*8])
    else $error("pulse or enable after a protect hit");
  a_clear_latch: assert property ((i_protect_error_clear && i_initiate_cycle_request_n) [*6]
    |-> !o_protect_error)
    else $error("latch still set under a held clear");
  a_latch_holds: assert property ((o_protect_error && !i_protect_error_clear && !i_wb_cyc) [*4]
    |=> o_protect_error)
    else $error("latch dropped without a clear");
  a_hold_stable: assert property (wr_en |->
    $stable(o_element_address) && $stable(o_element_write_data))
    else $error("address or data moved during the write pulse");
  a_read_answer: assert property ($rose(o_memory_initiate_pulse) ##1 !o_memory_initiate_pulse
    |-> ##2 o_outbound_valid)
    else $error("read pulse without outbound word");
endmodule // memory_write_cycle_protect_properties

bind memory_write_cycle_protect memory_write_cycle_protect_properties
  #(.DELAY_CYCLES(DELAY_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)) u_props
  (.i_clock(i_clock), .i_reset_n(i_reset_n),
  .i_initiate_cycle_request_n(i_initiate_cycle_request_n),
  .i_read_not_write_n(i_read_not_write_n), .i_protect_error_clear(i_protect_error_clear),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_element_address(o_element_address),
  .o_element_write_data(o_element_write_data),
  .o_memory_initiate_pulse(o_memory_initiate_pulse),
  .o_write_enable_outer(o_write_enable_outer), .o_write_enable_inner(o_write_enable_inner),
  .o_outbound_valid(o_outbound_valid), .o_protect_error(o_protect_error), .o_wb_ack(o_wb_ack));

/* sim/element_memory_model.sv */
// Purpose: behavioural element memory at the far side of the front end
// Assumes: address and write data in true polarity, read data returned active low
// Notes: read lines show the addressed word at all times
`timescale 1ns/100ps
`include "memory_write_cycle_protect_defines.svh"

module element_memory_model
(
  input wire logic i_clock,
  input wire logic [10:0] i_address,
  input wire logic [63:0] i_write_data,
  input wire logic i_initiate_pulse,
  input wire logic i_enable_outer,
  input wire logic i_enable_inner,
  output logic [63:0] o_read_data_n
);
  // ==========================================================================
  // storage, one word per address
  logic [63:0] mem [0:2047];
  logic [63:0] mask;
  initial
    foreach (mem[i])
      mem[i] = 64'h0;
  assign mask = ({64{i_enable_outer}} & `OUTER_HALF_MASK) |
    ({64{i_enable_inner}} & ~`OUTER_HALF_MASK);
  always @(posedge i_clock)
  begin
    if (i_initiate_pulse)
      mem[i_address] <= (mem[i_address] & ~mask) | (i_write_data & mask);
  end
  assign o_read_data_n = ~mem[i_address];
endmodule // element_memory_model

/* sim/memory_write_cycle_protect_tb_top.sv */
// Purpose: self-checking bench for the write-cycle front end
// Assumes: default delay and pulse lengths; memory model starts cleared
// Notes: expected words come from a bench copy of the memory
`timescale 1ns/100ps
`include "memory_write_cycle_protect_defines.svh"

module memory_write_cycle_protect_tb_top;
  // ==========================================================================
  // signals
  logic clock = 1'h0;
  logic reset_n = 1'h0;
  logic sel_n = 1'h1, req_n = 1'h1, rnw_n = 1'h1, prot_n = 1'h1, clr = 1'h0, xfer_n = 1'h1;
  logic [1:0] dsel_n = 2'h3, half_n = 2'h0;
  logic [10:0] addr_n = 11'h7FF;
  logic [63:0] pe_n = '1, io_n = '1;
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic [3:0] sel = 4'hF;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rd, wb_q;
  logic [10:0] m_addr;
  logic [63:0] m_wdata, m_rdata_n, out_data;
  logic pulse, en_o, en_i, out_buf, out_valid, perr, ack, irq, exp_perr = 1'h0;
  logic [63:0] exp_mem [0:2047];
  logic [64:0] exp_q [$];
  logic [1:0] wr_tab [3] = '{`DSEL_CU, `DSEL_PE, `DSEL_IO};
  logic [1:0] rd_tab [3] = '{`DSEL_PE, `DSEL_IO, `DSEL_BUFFER};
  logic [7:0] ra [5] = '{`REG_STATUS_ADDR, `REG_ENABLE_ADDR, `REG_CONTROL_ADDR,
    `REG_STATE_ADDR, 8'h40};
  logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h1, 32'h2, 32'h0};
  logic [10:0] a = 11'h080;
  int errors = 0, n_tests = 0, seed = 28932, op, k;

  initial
    forever #10 clock = ~clock;

  memory_write_cycle_protect DUT (.i_clock(clock), .i_reset_n(reset_n),
    .i_memory_select_n(sel_n), .i_initiate_cycle_request_n(req_n), .i_read_not_write_n(rnw_n),
    .i_protect_low_region_request_n(prot_n), .i_protect_error_clear(clr),
    .i_transfer_request_n(xfer_n), .i_data_select_n(dsel_n), .i_half_select_n(half_n),
    .i_word_address_n(addr_n), .i_pe_write_data_n(pe_n), .i_io_write_data_n(io_n),
    .i_element_read_data_n(m_rdata_n), .o_element_address(m_addr),
    .o_element_write_data(m_wdata), .o_memory_initiate_pulse(pulse),
    .o_write_enable_outer(en_o), .o_write_enable_inner(en_i), .o_outbound_data(out_data),
    .o_outbound_to_buffer(out_buf), .o_outbound_valid(out_valid), .o_protect_error(perr),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_dat(rd), .o_wb_ack(ack), .o_interrupt(irq));

  element_memory_model u_mem (.i_clock(clock), .i_address(m_addr), .i_write_data(m_wdata),
    .i_initiate_pulse(pulse), .i_enable_outer(en_o), .i_enable_inner(en_i),
    .o_read_data_n(m_rdata_n));

  // ==========================================================================
  // shared tasks
  task automatic give_verdict();
    $display("errors %0d, comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [64:0] got, input logic [64:0] want);
    n_tests++;
    if (got !== want)
    begin
      errors++;
      $display("unexpected at %0t: got %h, want %h", $time, got, want);
    end
  endtask

  // waits for ack however long; only the watchdog ends a hang
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge clock);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= ad;
    wdat <= d;
    for (n = 0; ack !== 1'h1; n++)
      @(posedge clock);
    check(65'(n), 65'h2);
    wb_q = rd;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask

  function automatic logic [63:0] hmask(input logic [1:0] ds, input logic [1:0] hs);
    logic [63:0] m;
    m = (hs[0] ? 64'h0 : `OUTER_HALF_MASK) | (hs[1] ? 64'h0 : ~`OUTER_HALF_MASK);
    return (ds == `DSEL_PE) ? m : '1;
  endfunction

  // op 0 write, 1 read, 2 transfer; the window covers sync, delay and pulse
  task automatic mem_cycle(input int o, input logic [1:0] ds, input logic [1:0] hs,
    input logic [10:0] ad, input logic [63:0] d, input logic prot);
    int pulses;
    int nv;
    logic hit;
    logic [63:0] m;
    pulses = 0;
    nv = 0;
    hit = prot && (o == 0) && (ad[10:7] == 4'h0);
    m = hmask(ds, hs);
    if (o == 1)
      exp_q.push_back({ds == `DSEL_BUFFER, exp_mem[ad]});
    if (o == 2)
      exp_q.push_back({1'h1, d & m});
    @(posedge clock);
    dsel_n <= ~ds;
    half_n <= hs;
    addr_n <= ~ad;
    pe_n <= (ds == `DSEL_IO) ? d : ~d;
    io_n <= (ds == `DSEL_IO) ? ~d : d;
    prot_n <= ~prot;
    rnw_n <= 1'(o != 1);
    xfer_n <= 1'(o != 2);
    sel_n <= 1'(o == 2);
    req_n <= 1'(o == 2);
    repeat (16)
    begin
      @(posedge clock);
      pulses += pulse;
      if (out_valid === 1'h1)
      begin
        nv++;
        check({out_buf, out_data}, exp_q.pop_front());
      end
    end
    sel_n <= 1'h1;
    req_n <= 1'h1;
    xfer_n <= 1'h1;
    repeat (6) @(posedge clock);
    if (o == 0 && !hit)
      exp_mem[ad] = (exp_mem[ad] & ~m) | (d & m);
    exp_perr = exp_perr | hit;
    check(65'(nv), 65'(o != 0));
    check(65'(pulses), 65'(hit || o == 2 ? 0 : o == 0 ? `WRITE_PULSE_CYCLES : 1));
    check(65'(u_mem.mem[ad]), 65'(exp_mem[ad]));
    check(65'(perr), 65'(exp_perr));
  endtask

  // ==========================================================================
  // main sequence
  initial
  begin
    foreach (exp_mem[i])
      exp_mem[i] = 64'h0;
    repeat (16) @(posedge clock);
    reset_n <= 1'h1;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 5; i++)
    begin
      wb(1'h0, ra[i], 32'h0);
      check(65'(wb_q), 65'(rv[i]));
    end
    wb(1'h1, `REG_ENABLE_ADDR, 32'h2);
    mem_cycle(0, `DSEL_CU, 2'h0, 11'h080, {$random(seed), $random(seed)}, 1'h1);
    check(65'(irq), 65'h1);
    wb(1'h1, `REG_CLEAR_ADDR, 32'hF);
    check(65'(irq), 65'h0);
    mem_cycle(0, `DSEL_IO, 2'h0, 11'h07F, {$random(seed), $random(seed)}, 1'h1);
    for (int i = 0; i < 30; i++)
    begin
      op = i % 3;
      k = $unsigned($random(seed)) % 3;
      if (op == 0)
        a = 11'($random(seed)) & 11'h0FF;
      mem_cycle(op, op == 1 ? rd_tab[k] : op == 2 ? `DSEL_PE : wr_tab[k], 2'(k), a,
        {$random(seed), $random(seed)}, 1'($random(seed)));
    end
    clr <= 1'h1;
    repeat (7) @(posedge clock);
    clr <= 1'h0;
    exp_perr = 1'h0;
    check(65'(perr), 65'h0);
    wb(1'h1, `REG_CLEAR_ADDR, 32'hF);
    wb(1'h1, `REG_ENABLE_ADDR, 32'h1);
    mem_cycle(0, `DSEL_PE, 2'h0, 11'h000, {$random(seed), $random(seed)}, 1'h1);
    check(65'(irq), 65'h1);
    wb(1'h1, `REG_ENABLE_ADDR, 32'h0);
    check(65'(irq), 65'h0);
    wb(1'h1, `REG_CONTROL_ADDR, 32'h3);
    exp_perr = 1'h0;
    check(65'(perr), 65'h0);
    wb(1'h0, `REG_STATUS_ADDR, 32'h0);
    check(65'(wb_q), 65'h1);
    give_verdict();
  end

  // the whole run needs well under 3000 cycles
  initial
  begin
    repeat (20000) @(posedge clock);
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule // memory_write_cycle_protect_tb_top
